/* File: bts_link_asserts.sv */
`timescale 1ns/100ps
module bts_link_asserts import bts_pkg::*; (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic in_clk_p,
    input wire logic in_clk_n,
    input wire logic out_clk_p,
    input wire logic out_clk_n,
    input wire logic read_select_n,
    input wire logic write_select_n,
    input wire logic [BTS_DATA_W-1:0] read_data_out,
    input wire logic read_data_oe
);
    logic [4:0] rd_age_r;

    // Saturating age, so a long idle stretch cannot wrap
    always_ff @(posedge core_clk) begin
        if (!rstn || !read_select_n) begin
            rd_age_r <= 5'h0;
        end else if (rd_age_r != 5'h1f) begin
            rd_age_r <= rd_age_r + 5'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_kp_cycle;
        in_clk_p ##1 !in_clk_p [*2] ##1 in_clk_p;
    endsequence
    sequence s_burst;
        read_data_oe [*4];
    endsequence

    a_oe_after_reset: assert property ($rose(rstn) |-> !read_data_oe)
        else $error("read bus driven after reset");
    a_oe_has_cause: assert property (
        $rose(read_data_oe) |-> rd_age_r < 5'h10)
        else $error("read bus driven without request");
    a_burst_two_words: assert property (
        $rose(read_data_oe) |-> s_burst)
        else $error("read burst too short");
    a_bus_release: assert property (
        $fell(read_data_oe) |-> $past(read_data_oe, 4))
        else $error("read bus released mid burst");
    a_idle_released: assert property (
        rd_age_r == 5'h1f |-> !read_data_oe)
        else $error("read bus held while idle");
    a_word_stable: assert property (
        $rose(read_data_oe) |=> $stable(read_data_out))
        else $error("low word not held");
    a_rsel_on_kp: assert property (
        $changed(read_select_n) |-> $rose(in_clk_p))
        else $error("read select moved off input rise");
    a_wsel_on_kp: assert property (
        $changed(write_select_n) |-> $rose(in_clk_p))
        else $error("write select moved off input rise");
    a_kp_period: assert property ($rose(in_clk_p) |=> s_kp_cycle)
        else $error("input clock period wrong");
    a_clk_pair: assert property (in_clk_n == !in_clk_p)
        else $error("input clock pair not complementary");
    a_out_clk: assert property (
        (out_clk_p && out_clk_n) ||
        (out_clk_p == in_clk_p && out_clk_n == in_clk_n))
        else $error("output clock pair neither copy nor strap");
endmodule : bts_link_asserts

/* File: bts_link_if.sv */
`timescale 1ns/100ps
interface bts_link_if import bts_pkg::*; #(
    parameter int AW = BTS_ADDR_W
) ();
    logic in_clk_p;
    logic in_clk_n;
    logic out_clk_p;
    logic out_clk_n;
    logic read_select_n;
    logic write_select_n;
    logic [1:0] lane_write_mask_n;
    logic [AW-1:0] addr;
    logic [BTS_DATA_W-1:0] write_data_in;
    logic [BTS_DATA_W-1:0] read_data_out;
    logic read_data_oe;

    modport dev (
        input in_clk_p,
        input in_clk_n,
        input out_clk_p,
        input out_clk_n,
        input read_select_n,
        input write_select_n,
        input lane_write_mask_n,
        input addr,
        input write_data_in,
        output read_data_out,
        output read_data_oe
    );

    modport ctl (
        output in_clk_p,
        output in_clk_n,
        output out_clk_p,
        output out_clk_n,
        output read_select_n,
        output write_select_n,
        output lane_write_mask_n,
        output addr,
        output write_data_in,
        input read_data_out,
        input read_data_oe
    );
endinterface : bts_link_if

/* File: bts_pkg.sv */
package bts_pkg;
    localparam int BTS_DATA_W = 18;
    localparam int BTS_ADDR_W = 18;
    localparam int BTS_LANE_SPLIT = 9;
    localparam int BTS_RECAL_CYCLES = 1024;
    localparam int BTS_RECAL_W = 10;
    localparam logic [1:0] BTS_PH_KP = 2'h0;
    localparam logic [1:0] BTS_PH_PRE_KN = 2'h1;
    localparam logic [1:0] BTS_PH_KN = 2'h2;
    localparam logic [1:0] BTS_PH_SLOT = 2'h3;
    localparam logic [1:0] BTS_CAP_LO = 2'h1;
    localparam logic [1:0] BTS_CAP_HI = 2'h3;

    typedef enum logic [1:0] {
        BTS_OS_IDLE = 2'b00,
        BTS_OS_LO = 2'b01,
        BTS_OS_HI = 2'b10
    } bts_ostate_t;

    // Active-low lane masks; a high mask bit keeps the stored lane
    function automatic logic [BTS_DATA_W-1:0] bts_lane_merge(
        input logic [BTS_DATA_W-1:0] old_w,
        input logic [BTS_DATA_W-1:0] new_w,
        input logic [1:0] mask_n
    );
        logic [BTS_DATA_W-1:0] res;
        res = old_w;
        if (!mask_n[0]) begin
            res[BTS_LANE_SPLIT-1:0] = new_w[BTS_LANE_SPLIT-1:0];
        end
        if (!mask_n[1]) begin
            res[BTS_DATA_W-1:BTS_LANE_SPLIT] =
                new_w[BTS_DATA_W-1:BTS_LANE_SPLIT];
        end
        return res;
    endfunction : bts_lane_merge
endpackage : bts_pkg

/* File: bts_sram_ctl.sv */
`timescale 1ns/100ps
module bts_sram_ctl import bts_pkg::*; #(
    parameter int AW = BTS_ADDR_W
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic strap_single,
    output logic slot,
    input wire logic rd_req,
    input wire logic [AW-1:0] rd_addr,
    input wire logic wr_req,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [2*BTS_DATA_W-1:0] wr_data,
    input wire logic [3:0] wr_mask_n,
    output logic [2*BTS_DATA_W-1:0] rd_data,
    output logic rd_valid,
    bts_link_if.ctl link
);
    localparam int DW = BTS_DATA_W;

    generate
        if (AW < 1 || AW > BTS_ADDR_W) begin : g_bad_aw
            $error("bts_sram_ctl: AW out of range");
        end
    endgenerate

    logic [1:0] ph_r;
    logic [1:0] ph_nxt;
    logic kp_nxt;
    logic kn_nxt;
    logic strap_hold;
    logic out_cp_r;
    logic out_cn_r;
    logic slot_r;
    logic strap_done_r;
    logic single_r;
    logic kp_r;
    logic kn_r;
    logic rsel_n_r;
    logic wsel_n_r;
    logic [1:0] mask_n_r;
    logic [AW-1:0] addr_r;
    logic [DW-1:0] dout_r;
    logic wr_act_r;
    logic [AW-1:0] wr_addr_h_r;
    logic [DW-1:0] wr_hi_r;
    logic [1:0] wr_mask_hi_r;
    logic [DW:0] rx1_r;
    logic [DW:0] rx2_r;
    logic [1:0] cap_cnt_r;
    logic [DW-1:0] lo_hold_r;
    logic [2*DW-1:0] rd_data_r;
    logic rd_valid_r;

    assign ph_nxt = ph_r + 2'h1;
    assign kp_nxt = (ph_nxt == BTS_PH_KP) || (ph_nxt == BTS_PH_PRE_KN);
    assign kn_nxt = (ph_nxt == BTS_PH_KN) || (ph_nxt == BTS_PH_SLOT);
    assign strap_hold = strap_done_r ? single_r : strap_single;

    // Input clocks: four core cycles per link cycle
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ph_r <= BTS_PH_SLOT;
            slot_r <= 1'b0;
            kp_r <= 1'b0;
            kn_r <= 1'b1;
            out_cp_r <= 1'b1;
            out_cn_r <= 1'b1;
            strap_done_r <= 1'b0;
            single_r <= 1'b0;
        end else if (ce) begin
            ph_r <= ph_nxt;
            slot_r <= (ph_nxt == BTS_PH_SLOT);
            kp_r <= kp_nxt;
            kn_r <= kn_nxt;
            // Strapped single mode holds the output clocks high
            out_cp_r <= strap_hold | kp_nxt;
            out_cn_r <= strap_hold | kn_nxt;
            if (!strap_done_r) begin
                strap_done_r <= 1'b1;
                single_r <= strap_single;
            end
        end
    end

    // Requests are taken while slot is high and launch with the rise
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rsel_n_r <= 1'b1;
            wsel_n_r <= 1'b1;
            mask_n_r <= 2'h3;
            addr_r <= '0;
            dout_r <= '0;
            wr_act_r <= 1'b0;
            wr_addr_h_r <= '0;
            wr_hi_r <= '0;
            wr_mask_hi_r <= 2'h3;
        end else if (ce && ph_r == BTS_PH_SLOT) begin
            rsel_n_r <= ~rd_req;
            wsel_n_r <= ~wr_req;
            wr_act_r <= wr_req;
            addr_r <= rd_addr;
            dout_r <= wr_data[DW-1:0];
            mask_n_r <= wr_mask_n[1:0];
            wr_addr_h_r <= wr_addr;
            wr_hi_r <= wr_data[2*DW-1:DW];
            wr_mask_hi_r <= wr_mask_n[3:2];
        end else if (ce && ph_r == BTS_PH_PRE_KN && wr_act_r) begin
            addr_r <= wr_addr_h_r;
            dout_r <= wr_hi_r;
            mask_n_r <= wr_mask_hi_r;
        end
    end

    // Read bus crosses via two flops; words stand two core cycles each
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rx1_r <= '0;
            rx2_r <= '0;
            cap_cnt_r <= 2'h0;
            lo_hold_r <= '0;
            rd_data_r <= '0;
            rd_valid_r <= 1'b0;
        end else if (ce) begin
            rx1_r <= {link.read_data_oe, link.read_data_out};
            rx2_r <= rx1_r;
            rd_valid_r <= 1'b0;
            if (!rx2_r[DW]) begin
                cap_cnt_r <= 2'h0;
            end else begin
                cap_cnt_r <= cap_cnt_r + 2'h1;
                if (cap_cnt_r == BTS_CAP_LO) begin
                    lo_hold_r <= rx2_r[DW-1:0];
                end
                if (cap_cnt_r == BTS_CAP_HI) begin
                    rd_data_r <= {rx2_r[DW-1:0], lo_hold_r};
                    rd_valid_r <= 1'b1;
                end
            end
        end
    end

    assign slot = slot_r;
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign link.in_clk_p = kp_r;
    assign link.in_clk_n = kn_r;
    assign link.out_clk_p = out_cp_r;
    assign link.out_clk_n = out_cn_r;
    assign link.read_select_n = rsel_n_r;
    assign link.write_select_n = wsel_n_r;
    assign link.lane_write_mask_n = mask_n_r;
    assign link.addr = addr_r;
    assign link.write_data_in = dout_r;
endmodule : bts_sram_ctl

/* File: bts_sram_dev.sv */
`timescale 1ns/100ps
module bts_sram_dev import bts_pkg::*; #(
    parameter int AW = BTS_ADDR_W
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    bts_link_if.dev link,
    output logic single_clock_mode,
    output logic impedance_update
);
    localparam int DW = BTS_DATA_W;
    localparam int SW = 8 + AW + DW;

    generate
        if (AW < 1 || AW > BTS_ADDR_W) begin : g_bad_aw
            $error("bts_sram_dev: AW out of range");
        end
    endgenerate

    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic [3:0] clk_prev_r;
    logic kp_s;
    logic kn_s;
    logic cp_s;
    logic cn_s;
    logic rsel_s;
    logic wsel_s;
    logic [1:0] mask_s;
    logic [AW-1:0] addr_s;
    logic [DW-1:0] din_s;
    logic kp_rise;
    logic kn_rise;
    logic op_rise;
    logic on_rise;

    logic strap_done_r;
    logic single_r;
    logic rd_q_r;
    logic [AW-1:0] rd_addr_r;
    logic rd_due_r;
    logic [AW-1:0] due_addr_r;
    logic wr_pend_r;
    logic [DW-1:0] wr_lo_r;
    logic [1:0] wr_lo_mask_r;
    logic [2*DW-1:0] mem_r [2**AW];
    logic [DW-1:0] q_r;
    logic [DW-1:0] q_hi_r;
    logic oe_r;
    bts_ostate_t ostate_r;
    logic [BTS_RECAL_W-1:0] recal_cnt_r;
    logic recal_r;

    logic due_now;
    logic take;
    logic [AW-1:0] take_addr;
    logic commit;
    logic [2*DW-1:0] wr_word;
    logic [2*DW-1:0] rd_word;

    // Every pin, clocks included, crosses through two flops alike
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            // Idle pin levels, so no false edge follows reset
            sync1_r <= {8'h7f, {(AW + DW){1'b0}}};
            sync2_r <= {8'h7f, {(AW + DW){1'b0}}};
            clk_prev_r <= 4'h7;
        end else if (ce) begin
            sync1_r <= {link.in_clk_p, link.in_clk_n, link.out_clk_p,
                link.out_clk_n, link.read_select_n, link.write_select_n,
                link.lane_write_mask_n, link.addr, link.write_data_in};
            sync2_r <= sync1_r;
            clk_prev_r <= {kp_s, kn_s, cp_s, cn_s};
        end
    end

    assign {kp_s, kn_s, cp_s, cn_s, rsel_s, wsel_s, mask_s, addr_s,
        din_s} = sync2_r;
    assign kp_rise = ce & kp_s & ~clk_prev_r[3];
    assign kn_rise = ce & kn_s & ~clk_prev_r[2];
    // Stopped output clocks give no edges, so single mode uses the input rises
    assign op_rise = single_r ? kp_rise :
        (ce & cp_s & ~clk_prev_r[1]);
    assign on_rise = single_r ? kn_rise :
        (ce & cn_s & ~clk_prev_r[0]);

    // Strap read at first input rise, after the sync chain has settled
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            strap_done_r <= 1'b0;
            single_r <= 1'b0;
        end else if (kp_rise && !strap_done_r) begin
            strap_done_r <= 1'b1;
            single_r <= cp_s & cn_s;
        end
    end

    assign due_now = rd_due_r | (kp_rise & rd_q_r);
    assign take = op_rise & due_now;
    assign take_addr = rd_due_r ? due_addr_r : rd_addr_r;

    // Read request pipeline: taken at t, due from t+1
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rd_q_r <= 1'b0;
            rd_addr_r <= '0;
            rd_due_r <= 1'b0;
            due_addr_r <= '0;
        end else if (kp_rise) begin
            rd_q_r <= ~rsel_s;
            if (!rsel_s) begin
                rd_addr_r <= addr_s;
            end
            if (rd_q_r) begin
                due_addr_r <= rd_addr_r;
            end
            rd_due_r <= take ? (rd_due_r & rd_q_r) : rd_q_r;
        end else if (take) begin
            rd_due_r <= 1'b0;
        end
    end

    // Write port: low word on positive rise, rest on negative rise
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wr_pend_r <= 1'b0;
            wr_lo_r <= '0;
            wr_lo_mask_r <= 2'h3;
        end else if (kp_rise && !wsel_s) begin
            wr_pend_r <= 1'b1;
            wr_lo_r <= din_s;
            wr_lo_mask_r <= mask_s;
        end else if (kn_rise) begin
            // Deselect in between does not cancel an accepted write
            wr_pend_r <= 1'b0;
        end
    end

    assign commit = kn_rise & wr_pend_r;

    // Lower word lives in the low half of each location
    always_comb begin
        wr_word[DW-1:0] = bts_lane_merge(mem_r[addr_s][DW-1:0], wr_lo_r,
            wr_lo_mask_r);
        wr_word[2*DW-1:DW] = bts_lane_merge(mem_r[addr_s][2*DW-1:DW],
            din_s, mask_s);
    end

    always_ff @(posedge core_clk) begin
        if (commit) begin
            mem_r[addr_s] <= wr_word;
        end
    end

    // Forward a write landing in the same cycle as the fetch
    assign rd_word = (commit && addr_s == take_addr) ? wr_word :
        mem_r[take_addr];

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            q_r <= '0;
            q_hi_r <= '0;
            oe_r <= 1'b0;
            ostate_r <= BTS_OS_IDLE;
        end else if (take) begin
            q_r <= rd_word[DW-1:0];
            q_hi_r <= rd_word[2*DW-1:DW];
            oe_r <= 1'b1;
            ostate_r <= BTS_OS_LO;
        end else begin
            case (ostate_r)
                BTS_OS_LO: begin
                    if (on_rise) begin
                        q_r <= q_hi_r;
                        ostate_r <= BTS_OS_HI;
                    end
                end
                BTS_OS_HI: begin
                    if (op_rise) begin
                        // Release so another bank can drive next cycle
                        oe_r <= 1'b0;
                        ostate_r <= BTS_OS_IDLE;
                    end
                end
                BTS_OS_IDLE: begin
                    oe_r <= 1'b0;
                end
                default: begin
                    oe_r <= 1'b0;
                    ostate_r <= BTS_OS_IDLE;
                end
            endcase
        end
    end

    // Counts input clock cycles, not core cycles
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            recal_cnt_r <= '0;
            recal_r <= 1'b0;
        end else if (ce) begin
            recal_r <= 1'b0;
            if (kp_rise) begin
                recal_cnt_r <= recal_cnt_r + 1'b1;
                recal_r <= (recal_cnt_r ==
                    BTS_RECAL_W'(BTS_RECAL_CYCLES - 1));
            end
        end
    end

    assign link.read_data_out = q_r;
    assign link.read_data_oe = oe_r;
    assign single_clock_mode = single_r;
    assign impedance_update = recal_r;
endmodule : bts_sram_dev

/* File: tb_top.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    fail_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top import bts_pkg::*;;
    localparam int AW = 8;
    logic core_clk = 1'b0;
    logic rstn, ce, strap_single, rd_req, wr_req, slot, rd_valid;
    logic single_clock_mode, impedance_update;
    logic [AW-1:0] rd_addr, wr_addr;
    logic [35:0] wr_data, rd_data;
    logic [3:0] wr_mask_n;
    int fail_count, samples_checked;

    always #50 core_clk = ~core_clk;

    bts_link_if #(.AW(AW)) link ();
    bts_sram_dev #(.AW(AW)) i_bts_sram_dev (.core_clk(core_clk),
        .rstn(rstn), .ce(ce), .link(link),
        .single_clock_mode(single_clock_mode),
        .impedance_update(impedance_update));
    bts_sram_ctl #(.AW(AW)) i_bts_sram_ctl (.core_clk(core_clk),
        .rstn(rstn), .ce(ce), .strap_single(strap_single), .slot(slot),
        .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_mask_n(wr_mask_n),
        .rd_data(rd_data), .rd_valid(rd_valid), .link(link));
    bts_link_asserts i_asserts (.core_clk(core_clk), .rstn(rstn),
        .in_clk_p(link.in_clk_p), .in_clk_n(link.in_clk_n),
        .out_clk_p(link.out_clk_p), .out_clk_n(link.out_clk_n),
        .read_select_n(link.read_select_n),
        .write_select_n(link.write_select_n),
        .read_data_out(link.read_data_out),
        .read_data_oe(link.read_data_oe));

    function automatic logic [17:0] mrg(input logic [17:0] o, n,
                                        input logic [1:0] m);
        return {m[1] ? o[17:9] : n[17:9], m[0] ? o[8:0] : n[8:0]};
    endfunction : mrg

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic do_reset(input logic single);
        strap_single = single;
        rstn = 1'b0;
        repeat (5) @(negedge core_clk);
        rstn = 1'b1;
        `CHK(link.read_data_oe, 1'b0)
        `CHK({link.read_select_n, link.write_select_n}, 2'h3)
    endtask : do_reset

    // Request is raised at the negedge where slot shows, taken next edge
    task automatic issue(input logic r, input logic [AW-1:0] ra,
        input logic w, input logic [AW-1:0] wa, input logic [35:0] wd,
        input logic [3:0] m);
        int n;
        n = 0;
        @(negedge core_clk);
        while (slot !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        rd_req = r;
        rd_addr = ra;
        wr_req = w;
        wr_addr = wa;
        wr_data = wd;
        wr_mask_n = m;
        @(negedge core_clk);
        rd_req = 1'b0;
        wr_req = 1'b0;
    endtask : issue

    task automatic get(input logic [35:0] exp);
        int n;
        n = 0;
        while (rd_valid !== 1'b1 && n < 30) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n >= 8 && n <= 19, 1'b1)
        `CHK(rd_data, exp)
        `CHK(link.read_data_oe, 1'b0)
    endtask : get

    task automatic t_basic;
        issue(1'b0, '0, 1'b1, 8'h05, 36'h9_abcd_1234, 4'h0);
        issue(1'b0, '0, 1'b1, 8'h06, 36'h1_5a5a_c3c3, 4'h0);
        issue(1'b1, 8'h05, 1'b0, '0, '0, 4'hf);
        get(36'h9_abcd_1234);
        issue(1'b1, 8'h06, 1'b0, '0, '0, 4'hf);
        get(36'h1_5a5a_c3c3);
    endtask : t_basic

    task automatic t_lanes;
        logic [35:0] o, n;
        for (int i = 0; i < 16; i++) begin
            o = 36'ha_aaaa_aaaa;
            n = 36'h5_5555_5550 | 36'(i);
            issue(1'b0, '0, 1'b1, 8'h10, o, 4'h0);
            issue(1'b0, '0, 1'b1, 8'h10, n, 4'(i));
            issue(1'b1, 8'h10, 1'b0, '0, '0, 4'hf);
            get({mrg(o[35:18], n[35:18], 2'(i >> 2)),
                 mrg(o[17:0], n[17:0], 2'(i))});
        end
    endtask : t_lanes

    task automatic t_collide;
        issue(1'b0, '0, 1'b1, 8'h20, 36'h0_1111_2222, 4'h0);
        issue(1'b1, 8'h20, 1'b1, 8'h20, 36'h3_3333_4444, 4'h0);
        get(36'h3_3333_4444);
        issue(1'b0, '0, 1'b1, 8'h20, 36'h5_6666_7777, 4'h0);
        issue(1'b1, 8'h20, 1'b0, '0, '0, 4'hf);
        get(36'h5_6666_7777);
    endtask : t_collide

    // Write inputs wiggle while the write port is idle
    task automatic t_ports;
        issue(1'b0, '0, 1'b1, 8'h30, 36'h7_0f0f_0f0f, 4'h0);
        issue(1'b1, 8'h30, 1'b0, 8'h30, 36'h0_dead_beef, 4'h0);
        get(36'h7_0f0f_0f0f);
        issue(1'b1, 8'h30, 1'b1, 8'h31, 36'h2_2222_1111, 4'h0);
        get(36'h7_0f0f_0f0f);
        issue(1'b1, 8'h31, 1'b0, '0, '0, 4'hf);
        get(36'h2_2222_1111);
    endtask : t_ports

    task automatic t_recal;
        int n;
        n = 0;
        while (impedance_update !== 1'b1 && n < 4200) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        @(negedge core_clk);
        while (impedance_update !== 1'b1 && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n + 1, 4 * BTS_RECAL_CYCLES)
    endtask : t_recal

    task automatic t_single;
        do_reset(1'b1);
        repeat (12) @(negedge core_clk);
        `CHK(single_clock_mode, 1'b1)
        repeat (8) begin
            @(negedge core_clk);
            `CHK(link.out_clk_p & link.out_clk_n, 1'b1)
        end
        issue(1'b0, '0, 1'b1, 8'h40, 36'h8_8888_9999, 4'h0);
        issue(1'b1, 8'h40, 1'b0, '0, '0, 4'hf);
        get(36'h8_8888_9999);
        do_reset(1'b0);
        repeat (12) @(negedge core_clk);
        `CHK(single_clock_mode, 1'b0)
    endtask : t_single

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        strap_single = 1'b0;
        rd_req = 1'b0;
        wr_req = 1'b0;
        rd_addr = '0;
        wr_addr = '0;
        wr_data = '0;
        wr_mask_n = 4'hf;
        fail_count = 0;
        samples_checked = 0;
        do_reset(1'b0);
        t_basic();
        t_lanes();
        t_collide();
        t_ports();
        t_recal();
        t_single();
        close_out();
    end

    // About five times the expected run length
    initial begin
        #4000000;
        fail_count++;
        close_out();
    end
endmodule : tb_top
